// ### hw/midi_sync_generator.sv
// MIDI sync generator: timecode, clock, song position and machine control out of one MIDI port
//
// Functional notes
// - Off sends no sync messages; timecode or clock selectable
// - Clock rate and position follow tempo
// - Rate 30 counts 30 frames, no drops
// - 29.97 non-drop advances without skipping numbers
// - 29.97 drop advances with drop numbering
// - Rate 25 gives 25 frames per second
// - Rate 24 gives 24 frames per second
// - Drop skips frames 0,1 except tenth minutes
// - Non-drop numbering has no gaps
// - Master only, never locks to incoming sync
// - Sent timecode is song time plus offset
// - Absolute view adds offset; relative starts zero
// - Machine control off suppresses all commands
// - Master mode mirrors play, stop, fast-forward
// - Playback start emits sync for sequencer
// - Song Position Pointer conveys clock position
// - Start sent when tempo map start reached
// - Tempo 25.0 to 250.0, paces clock
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`include "midi_sync_map.svh"
module midi_sync_generator
  import midi_sync_pkg::*;
#(
  parameter int unsigned CLK_HZ = `MS_CLK_HZ,
  parameter int unsigned QF_30 = CLK_HZ / 120,
  parameter int unsigned QF_2997 = 32'((64'(CLK_HZ) * 64'd1001) / 64'd120000),
  parameter int unsigned QF_25 = CLK_HZ / 100,
  parameter int unsigned QF_24 = CLK_HZ / 96,
  parameter int unsigned TEMPO_NUM = CLK_HZ / `MS_PPQN * 10 * 60,
  parameter int BIT_CYCLES = CLK_HZ / `MS_MIDI_BAUD
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // MIDI out line
  output logic midi_out
);
  // Control registers
  logic [6:0] ctrl_r; // Generator, rate, machine control, view
  tc_t offset_r; // Timecode minus song time
  logic [11:0] tempo_r; // Tenths of quarter notes per minute
  logic [15:0] map_start_r; // Tempo map start in sixteenths
  gen_mode_t gen;
  rate_t rate;
  logic mmc_master;
  logic abs_view;
  assign gen = gen_mode_t'(ctrl_r[`MS_GEN_LSB +: 2]);
  assign rate = rate_t'(ctrl_r[`MS_RATE_LSB +: 3]);
  assign mmc_master = ctrl_r[`MS_MMC_BIT];
  assign abs_view = ctrl_r[`MS_ABS_BIT];

  // Bus decode
  logic wr_en; // Write access phase
  logic setup; // Setup phase, read data captured here
  logic [31:0] rd_val;
  logic rd_err;
  logic [31:0] prdata_r;
  logic pslverr_r;
  assign wr_en = psel && penable && pwrite;
  assign setup = psel && !penable;
  assign pready = 1'b1; // Zero wait states
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  // Transport
  logic running_r;
  logic started_r; // Start message already queued this pass
  logic play_cmd, stop_cmd, ff_cmd, rtz_cmd;
  assign play_cmd = wr_en && paddr == `MS_TRANSPORT_OFS && pwdata[`MS_PLAY_BIT] && !running_r;
  assign stop_cmd = wr_en && paddr == `MS_TRANSPORT_OFS && pwdata[`MS_STOP_BIT] && running_r;
  assign ff_cmd = wr_en && paddr == `MS_TRANSPORT_OFS && pwdata[`MS_FF_BIT];
  assign rtz_cmd = wr_en && paddr == `MS_TRANSPORT_OFS && pwdata[`MS_RTZ_BIT] && !running_r;

  // Time bases
  logic [31:0] tempo_acc_r; // Clock tick accumulator
  logic clk_tick;
  logic [31:0] qf_cnt_r;
  logic qf_tick;
  logic [31:0] qf_period;
  logic [2:0] qf_piece_r;
  logic [2:0] sub16_r; // Clocks within a sixteenth
  logic [15:0] pos16_r; // Song position in sixteenths
  tc_t song_tc, tx_tc, qf_tc_r;
  logic [4:0] fps_max;
  logic [1:0] mtc_rate;

  // Pending messages; a new set wins over the clear by the sender
  logic pend_clk_r, pend_qf_r, pend_start_r, pend_stop_r, pend_spp_r, pend_mmc_r;
  logic [7:0] qf_byte_r, mmc_cmd_r;
  logic take_clk, take_qf, take_start, take_stop, take_spp, take_mmc;
  logic set_clk, set_qf, set_start;

  // Register writes; tempo is clamped into its legal range
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `MS_CTRL_RST;
      offset_r <= '0;
      tempo_r <= `MS_TEMPO_RST;
      map_start_r <= `MS_MAPSTART_RST;
    end else if (wr_en) begin
      unique case (paddr)
        `MS_CTRL_OFS: ctrl_r <= pwdata[6:0];
        `MS_OFFSET_OFS: offset_r <= pwdata[21:0];
        `MS_TEMPO_OFS: begin
          if (pwdata[11:0] < `MS_TEMPO_MIN || pwdata[31:12] != 20'h0) begin
            tempo_r <= (pwdata[31:12] != 20'h0) ? `MS_TEMPO_MAX : `MS_TEMPO_MIN;
          end else if (pwdata[11:0] > `MS_TEMPO_MAX) begin
            tempo_r <= `MS_TEMPO_MAX;
          end else begin
            tempo_r <= pwdata[11:0];
          end
        end
        `MS_MAPSTART_OFS: map_start_r <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Read mux, captured in the setup cycle so data is from flops in the access cycle
  always_comb begin
    rd_val = 32'h0;
    rd_err = 1'b0;
    unique case (paddr)
      `MS_CTRL_OFS: rd_val = {25'h0, ctrl_r};
      `MS_OFFSET_OFS: rd_val = {10'h0, offset_r};
      `MS_TEMPO_OFS: rd_val = {20'h0, tempo_r};
      `MS_MAPSTART_OFS: rd_val = {16'h0, map_start_r};
      `MS_TRANSPORT_OFS: rd_val = {30'h0, started_r, running_r};
      `MS_TIME_OFS: rd_val = {10'h0, abs_view ? tx_tc : song_tc};
      `MS_SONGPOS_OFS: rd_val = {13'h0, pos16_r, sub16_r};
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= pwrite ? 32'h0 : rd_val;
      pslverr_r <= rd_err;
    end
  end

  // Frame rate per rate select; unknown codes behave as 30
  always_comb begin
    unique case (rate)
      RATE_2997_NONDROP: begin qf_period = QF_2997; fps_max = 5'd29; mtc_rate = 2'h3; end
      RATE_2997_DROP: begin qf_period = QF_2997; fps_max = 5'd29; mtc_rate = 2'h2; end
      RATE_25: begin qf_period = QF_25; fps_max = 5'd24; mtc_rate = 2'h1; end
      RATE_24: begin qf_period = QF_24; fps_max = 5'd23; mtc_rate = 2'h0; end
      default: begin qf_period = QF_30; fps_max = 5'd29; mtc_rate = 2'h3; end
    endcase
  end

  // Quarter-frame pacing; four quarter-frames make one frame of song time
  assign qf_tick = running_r && qf_cnt_r >= qf_period - 32'h1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qf_cnt_r <= 32'h0;
      qf_piece_r <= 3'h0;
    end else if (!running_r) begin
      qf_cnt_r <= 32'h0;
      qf_piece_r <= 3'h0;
    end else if (qf_tick) begin
      qf_cnt_r <= 32'h0;
      qf_piece_r <= qf_piece_r + 3'h1;
    end else begin
      qf_cnt_r <= qf_cnt_r + 32'h1;
    end
  end

  tc_counter u_song_tc (
    .pclk(pclk),
    .presetn(presetn),
    .clear(rtz_cmd),
    .adv(qf_tick && qf_piece_r[1:0] == 2'h3),
    .fps_max(fps_max),
    .drop(rate == RATE_2997_DROP),
    .tc(song_tc)
  );

  // Field-wise add with carries; the sum wraps at 24 hours
  function automatic tc_t tc_add(input tc_t a, input tc_t b, input logic [4:0] fmax);
    logic [5:0] f;
    logic [6:0] s, m;
    logic [5:0] h;
    tc_t r;
    f = {1'b0, a.ff} + {1'b0, b.ff};
    r.ff = (f > {1'b0, fmax}) ? 5'(f - {1'b0, fmax} - 6'h1) : f[4:0];
    s = {1'b0, a.ss} + {1'b0, b.ss} + {6'h0, f > {1'b0, fmax}};
    r.ss = (s > 7'd59) ? 6'(s - 7'd60) : s[5:0];
    m = {1'b0, a.mm} + {1'b0, b.mm} + {6'h0, s > 7'd59};
    r.mm = (m > 7'd59) ? 6'(m - 7'd60) : m[5:0];
    h = {1'b0, a.hh} + {1'b0, b.hh} + {5'h0, m > 7'd59};
    r.hh = (h > 6'd23) ? 5'(h - 6'd24) : h[4:0];
    return r;
  endfunction
  assign tx_tc = tc_add(song_tc, offset_r, fps_max);

  // Tempo accumulator: one clock pulse each time the tempo sum passes the numerator
  assign clk_tick = running_r && (tempo_acc_r + {20'h0, tempo_r} >= TEMPO_NUM);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tempo_acc_r <= 32'h0;
    end else if (!running_r) begin
      tempo_acc_r <= 32'h0;
    end else if (clk_tick) begin
      tempo_acc_r <= tempo_acc_r + {20'h0, tempo_r} - TEMPO_NUM;
    end else begin
      tempo_acc_r <= tempo_acc_r + {20'h0, tempo_r};
    end
  end

  // Song position: six clocks per sixteenth, 24 per quarter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub16_r <= 3'h0;
      pos16_r <= 16'h0;
    end else if (rtz_cmd) begin
      sub16_r <= 3'h0;
      pos16_r <= 16'h0;
    end else if (clk_tick) begin
      sub16_r <= (sub16_r == `MS_CLK_PER_16TH - 3'h1) ? 3'h0 : sub16_r + 3'h1;
      if (sub16_r == `MS_CLK_PER_16TH - 3'h1) begin
        pos16_r <= pos16_r + 16'h1;
      end
    end
  end

  // Run state; the device never looks at incoming sync, it has no MIDI input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running_r <= 1'b0;
      started_r <= 1'b0;
    end else begin
      if (play_cmd) begin
        running_r <= 1'b1;
      end else if (stop_cmd) begin
        running_r <= 1'b0;
      end
      if (play_cmd || rtz_cmd) begin
        started_r <= 1'b0;
      end else if (set_start) begin
        started_r <= 1'b1;
      end
    end
  end

  // Event sources; start waits until the position pointer has been taken, so it never overtakes it
  assign set_start = running_r && !started_r && gen != GEN_OFF && pos16_r >= map_start_r && !pend_spp_r;
  assign set_clk = clk_tick && gen == GEN_CLOCK && started_r;
  assign set_qf = qf_tick && gen == GEN_MTC;

  // Pending flags, set beats take
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_clk_r <= 1'b0;
      pend_qf_r <= 1'b0;
      pend_start_r <= 1'b0;
      pend_stop_r <= 1'b0;
      pend_spp_r <= 1'b0;
      pend_mmc_r <= 1'b0;
    end else begin
      pend_clk_r <= set_clk || (pend_clk_r && !take_clk);
      pend_qf_r <= set_qf || (pend_qf_r && !take_qf);
      pend_start_r <= set_start || (pend_start_r && !take_start);
      pend_stop_r <= (stop_cmd && gen == GEN_CLOCK) || (pend_stop_r && !take_stop);
      pend_spp_r <= (play_cmd && gen == GEN_CLOCK) || (pend_spp_r && !take_spp);
      pend_mmc_r <= ((play_cmd || stop_cmd || ff_cmd) && mmc_master) || (pend_mmc_r && !take_mmc);
    end
  end

  // Message payloads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qf_byte_r <= 8'h0;
      qf_tc_r <= '0;
      mmc_cmd_r <= 8'h0;
    end else begin
      if (qf_tick && qf_piece_r == 3'h7) begin
        qf_tc_r <= tx_tc; // Latched for the next eight pieces
      end
      if (set_qf) begin
        unique case (qf_piece_r)
          3'h0: qf_byte_r <= {4'h0, qf_tc_r.ff[3:0]};
          3'h1: qf_byte_r <= {4'h1, 3'h0, qf_tc_r.ff[4]};
          3'h2: qf_byte_r <= {4'h2, qf_tc_r.ss[3:0]};
          3'h3: qf_byte_r <= {4'h3, 2'h0, qf_tc_r.ss[5:4]};
          3'h4: qf_byte_r <= {4'h4, qf_tc_r.mm[3:0]};
          3'h5: qf_byte_r <= {4'h5, 2'h0, qf_tc_r.mm[5:4]};
          3'h6: qf_byte_r <= {4'h6, qf_tc_r.hh[3:0]};
          3'h7: qf_byte_r <= {4'h7, 1'b0, mtc_rate, qf_tc_r.hh[4]};
        endcase
      end
      if (play_cmd) begin
        mmc_cmd_r <= `MS_MMC_PLAY;
      end else if (stop_cmd) begin
        mmc_cmd_r <= `MS_MMC_STOP;
      end else if (ff_cmd) begin
        mmc_cmd_r <= `MS_MMC_FF;
      end
    end
  end

  // Message sender: picks the most urgent pending message and streams its bytes
  tx_state_t tx_state_r;
  logic [7:0] msg_r [6];
  logic [2:0] len_r, idx_r;
  logic byte_ready;
  logic idle;
  assign idle = (tx_state_r == TX_IDLE);
  // Start leads clock so the receiver never counts a pulse before it runs
  assign take_start = idle && pend_start_r;
  assign take_clk = idle && !pend_start_r && pend_clk_r;
  assign take_stop = idle && !pend_clk_r && !pend_start_r && pend_stop_r;
  assign take_spp = idle && !pend_clk_r && !pend_start_r && !pend_stop_r && pend_spp_r;
  assign take_mmc = idle && !pend_clk_r && !pend_start_r && !pend_stop_r && !pend_spp_r && pend_mmc_r;
  assign take_qf = idle && !pend_clk_r && !pend_start_r && !pend_stop_r && !pend_spp_r && !pend_mmc_r
    && pend_qf_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_r <= TX_IDLE;
      len_r <= 3'h0;
      idx_r <= 3'h0;
      for (int i = 0; i < 6; i++) msg_r[i] <= 8'h0;
    end else begin
      unique case (tx_state_r)
        TX_IDLE: begin
          idx_r <= 3'h0;
          if (take_clk) begin
            msg_r[0] <= `MS_ST_CLOCK;
            len_r <= 3'h1;
            tx_state_r <= TX_SEND;
          end else if (take_start || take_stop) begin
            msg_r[0] <= take_start ? `MS_ST_START : `MS_ST_STOP;
            len_r <= 3'h1;
            tx_state_r <= TX_SEND;
          end else if (take_spp) begin
            msg_r[0] <= `MS_ST_SPP;
            msg_r[1] <= {1'b0, pos16_r[6:0]};
            msg_r[2] <= {1'b0, pos16_r[13:7]};
            len_r <= 3'h3;
            tx_state_r <= TX_SEND;
          end else if (take_mmc) begin
            msg_r[0] <= 8'hf0; // Universal real-time, all devices
            msg_r[1] <= 8'h7f;
            msg_r[2] <= 8'h7f;
            msg_r[3] <= 8'h06;
            msg_r[4] <= mmc_cmd_r;
            msg_r[5] <= 8'hf7;
            len_r <= 3'h6;
            tx_state_r <= TX_SEND;
          end else if (take_qf) begin
            msg_r[0] <= `MS_ST_QF;
            msg_r[1] <= qf_byte_r;
            len_r <= 3'h2;
            tx_state_r <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (byte_ready) begin
            idx_r <= idx_r + 3'h1;
            if (idx_r == len_r - 3'h1) begin
              tx_state_r <= TX_IDLE;
            end
          end
        end
      endcase
    end
  end

  midi_uart_tx #(.BIT_CYCLES(BIT_CYCLES)) u_uart (
    .pclk(pclk),
    .presetn(presetn),
    .data(msg_r[idx_r]),
    .valid(tx_state_r == TX_SEND),
    .ready(byte_ready),
    .tx(midi_out)
  );

  // Checks
  a_off_no_sync: assert property (@(posedge pclk) disable iff (!presetn)
    (gen == GEN_OFF) |-> !set_clk && !set_qf && !set_start) else $error("sync queued while generator off");
  a_mmc_off_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (!mmc_master && !pend_mmc_r) |=> !pend_mmc_r) else $error("machine control queued while off");
  a_mmc_play_sent: assert property (@(posedge pclk) disable iff (!presetn)
    (play_cmd && mmc_master) |=> pend_mmc_r && mmc_cmd_r == `MS_MMC_PLAY) else $error("play not mirrored");
  a_spp_on_play: assert property (@(posedge pclk) disable iff (!presetn)
    (play_cmd && gen == GEN_CLOCK) |=> pend_spp_r ##1 running_r) else $error("no position pointer at play");
  a_start_at_map: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(pend_start_r) |-> started_r && $past(pos16_r) >= $past(map_start_r)) else $error("early start");
  a_tempo_in_range: assert property (@(posedge pclk) disable iff (!presetn)
    tempo_r >= `MS_TEMPO_MIN && tempo_r <= `MS_TEMPO_MAX) else $error("tempo out of range");
  a_view_select: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && paddr == `MS_TIME_OFS && !abs_view) |=> prdata_r == {10'h0, $past(song_tc)})
    else $error("relative view shows offset");
  a_clock_sixteenth: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_tick && sub16_r == 3'h5 && !rtz_cmd) |=> sub16_r == 3'h0 && pos16_r == $past(pos16_r) + 16'h1)
    else $error("sixteenth not six clocks");
  a_qf_sequence: assert property (@(posedge pclk) disable iff (!presetn)
    (qf_tick && running_r) |=> qf_piece_r == $past(qf_piece_r) + 3'h1) else $error("quarter-frame order broken");
endmodule // midi_sync_generator

// ### hw/midi_uart_tx.sv
// Serial MIDI byte transmitter, 8N1
`timescale 1ns/1ns
`include "midi_sync_map.svh"
module midi_uart_tx #(
  parameter int BIT_CYCLES = `MS_CLK_HZ / `MS_MIDI_BAUD
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Byte stream
  input wire logic [7:0] data,
  input wire logic valid,
  output logic ready,
  // Line
  output logic tx
);
  logic [9:0] shift_r; // Start, data, stop
  logic [3:0] bits_r; // Bits left to send
  logic [12:0] baud_r; // Cycles left in the bit

  assign ready = (bits_r == 4'h0);

  // Shift out LSB first; line idles high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_r <= 10'h3ff;
      bits_r <= 4'h0;
      baud_r <= 13'h0;
    end else if (ready && valid) begin
      shift_r <= {1'b1, data, 1'b0};
      bits_r <= 4'ha;
      baud_r <= 13'(BIT_CYCLES - 1);
    end else if (bits_r != 4'h0) begin
      if (baud_r == 13'h0) begin
        shift_r <= {1'b1, shift_r[9:1]};
        bits_r <= bits_r - 4'h1;
        baud_r <= 13'(BIT_CYCLES - 1);
      end else begin
        baud_r <= baud_r - 13'h1;
      end
    end
  end

  // Line driven from the shift register, forced high while bits_r is zero
  assign tx = (bits_r == 4'h0) ? 1'b1 : shift_r[0];
endmodule // midi_uart_tx

// ### hw/tc_counter.sv
// Song time counter in hours, minutes, seconds and frames with drop-frame numbering
`timescale 1ns/1ns
module tc_counter
  import midi_sync_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic clear,
  input wire logic adv,
  input wire logic [4:0] fps_max,
  input wire logic drop,
  // Count
  output tc_t tc
);
  tc_t tc_r;
  assign tc = tc_r;

  // Advance one frame; a new minute not divisible by ten starts at frame 2 in drop mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tc_r <= '0;
    end else if (clear) begin
      tc_r <= '0;
    end else if (adv) begin
      if (tc_r.ff >= fps_max) begin
        tc_r.ff <= 5'h0;
        if (tc_r.ss == 6'd59) begin
          tc_r.ss <= 6'h0;
          tc_r.mm <= (tc_r.mm == 6'd59) ? 6'h0 : tc_r.mm + 6'h1;
          if (tc_r.mm == 6'd59) begin
            tc_r.hh <= (tc_r.hh == 5'd23) ? 5'h0 : tc_r.hh + 5'h1;
          end
          if (drop && (tc_r.mm % 6'd10) != 6'd9) begin
            tc_r.ff <= 5'h2;
          end
        end else begin
          tc_r.ss <= tc_r.ss + 6'h1;
        end
      end else begin
        tc_r.ff <= tc_r.ff + 5'h1;
      end
    end
  end

  a_drop_skip_frames: assert property (@(posedge pclk) disable iff (!presetn)
    (adv && !clear && drop && tc_r.ff >= fps_max && tc_r.ss == 6'd59 && (tc_r.mm % 6'd10) != 6'd9)
    |=> (tc_r.ff == 5'h2)) else $error("drop minute did not skip frames 0 and 1");
  a_nondrop_no_gap: assert property (@(posedge pclk) disable iff (!presetn)
    (adv && !clear && !drop && tc_r.ff < fps_max) |=> (tc_r.ff == $past(tc_r.ff) + 5'h1))
    else $error("non-drop frame numbering left a gap");
endmodule // tc_counter

// ### pkg/midi_sync_map.svh
// Register offsets, field positions, reset values and timing counts of the MIDI sync generator
`ifndef MIDI_SYNC_MAP_SVH
`define MIDI_SYNC_MAP_SVH
// Register byte offsets
`define MS_CTRL_OFS 8'h00
`define MS_OFFSET_OFS 8'h04
`define MS_TEMPO_OFS 8'h08
`define MS_MAPSTART_OFS 8'h0c
`define MS_TRANSPORT_OFS 8'h10
`define MS_TIME_OFS 8'h14
`define MS_SONGPOS_OFS 8'h18
// Control fields
`define MS_GEN_LSB 0
`define MS_RATE_LSB 2
`define MS_MMC_BIT 5
`define MS_ABS_BIT 6
// Transport command bits
`define MS_PLAY_BIT 0
`define MS_STOP_BIT 1
`define MS_FF_BIT 2
`define MS_RTZ_BIT 3
// Reset values
`define MS_CTRL_RST 7'h40
`define MS_TEMPO_RST 12'h4b0
`define MS_MAPSTART_RST 16'h0000
// Tempo limits in tenths of a quarter note per minute
`define MS_TEMPO_MIN 12'h0fa
`define MS_TEMPO_MAX 12'h9c4
// Timing
`define MS_CLK_HZ 125000000
`define MS_MIDI_BAUD 31250
`define MS_PPQN 24
`define MS_CLK_PER_16TH 3'h6
// MIDI status and MMC bytes
`define MS_ST_QF 8'hf1
`define MS_ST_SPP 8'hf2
`define MS_ST_CLOCK 8'hf8
`define MS_ST_START 8'hfa
`define MS_ST_STOP 8'hfc
`define MS_MMC_STOP 8'h01
`define MS_MMC_PLAY 8'h02
`define MS_MMC_FF 8'h04
`endif

// ### pkg/midi_sync_pkg.sv
// Types shared by the MIDI sync generator modules
package midi_sync_pkg;
  // Hours, minutes, seconds, frames
  typedef struct packed {
    logic [4:0] hh;
    logic [5:0] mm;
    logic [5:0] ss;
    logic [4:0] ff;
  } tc_t;
  // Sync generator selection
  typedef enum logic [1:0] {GEN_OFF = 2'h0, GEN_MTC = 2'h1, GEN_CLOCK = 2'h2} gen_mode_t;
  // Timecode rate select codes
  typedef enum logic [2:0] {
    RATE_30 = 3'h0, RATE_2997_NONDROP = 3'h1, RATE_2997_DROP = 3'h2, RATE_25 = 3'h3, RATE_24 = 3'h4
  } rate_t;
  // Message sender states
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} tx_state_t;
endpackage

// ### tb/midi_seq_model.sv
// Receiving sequencer model: decodes 8N1 MIDI bytes from the generator's line
`timescale 1ns/1ns
module midi_seq_model #(
  parameter int BIT_CYCLES = 4
) (
  // Clock and line
  input wire logic pclk,
  input wire logic rx,
  // Decoded bytes
  output logic [7:0] rx_byte,
  output logic rx_stb,
  output logic frame_err
);
  int i;
  // Sample each bit mid-cell; the strobe lasts one cycle so every byte is seen once
  initial begin
    rx_byte = 8'h00;
    rx_stb = 1'b0;
    frame_err = 1'b0;
    forever begin
      @(negedge rx);
      repeat (BIT_CYCLES / 2) @(posedge pclk);
      for (i = 0; i < 8; i++) begin
        repeat (BIT_CYCLES) @(posedge pclk);
        rx_byte[i] = rx;
      end
      repeat (BIT_CYCLES) @(posedge pclk);
      // A low stop bit means a broken frame
      if (rx !== 1'b1) begin
        frame_err <= 1'b1;
      end
      rx_stb <= 1'b1;
      @(posedge pclk);
      rx_stb <= 1'b0;
    end
  end
endmodule // midi_seq_model

// ### tb/midi_sync_generator_test.sv
// Self-checking bench for the MIDI sync generator
`timescale 1ns/1ns
module midi_sync_generator_test;
  import midi_sync_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, midi_out, stb, ferr;
  logic [7:0] paddr, rxb;
  logic [31:0] pwdata, prdata, r;
  logic [7:0] q[$];
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  // Short counts keep bytes at 40 cycles and frames at 12 cycles except at rate 30
  midi_sync_generator #(
    .QF_30(200), .QF_2997(3), .QF_25(3), .QF_24(3), .TEMPO_NUM(120000), .BIT_CYCLES(4)
  ) i_midi_sync_generator (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .midi_out(midi_out));
  midi_seq_model #(.BIT_CYCLES(4)) i_midi_seq_model (
    .pclk(pclk), .rx(midi_out), .rx_byte(rxb), .rx_stb(stb), .frame_err(ferr));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Collect received bytes; bound the run
  always @(posedge pclk) begin
    if (stb === 1'b1) q.push_back(rxb);
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One APB transfer, held until pready is sampled high, then an idle cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    check("pslverr", 32'(pslverr), 32'(a > 8'h18));
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Next received byte, within a bounded wait
  task automatic expect_bytes(input string name, input logic [7:0] exp[]);
    int n;
    foreach (exp[k]) begin
      n = 0;
      while (q.size() == 0 && n < 2000) begin
        @(posedge pclk);
        n++;
      end
      check(name, (q.size() > 0) ? 32'(q.pop_front()) : 32'hffff_ffff, 32'(exp[k]));
    end
  endtask
  // Stop, return to zero and drop whatever is still in flight
  task automatic park(input logic [31:0] ctrl);
    apb(1'b1, 8'h10, 32'h2);
    apb(1'b1, 8'h10, 32'h8);
    apb(1'b1, 8'h00, ctrl);
    repeat (400) @(posedge pclk);
    q.delete();
  endtask
  task automatic t_regs;
    apb(1'b0, 8'h00, 32'h0); check("ctrl", r, 32'h40);
    apb(1'b0, 8'h08, 32'h0); check("tempo", r, 32'h4b0);
    apb(1'b1, 8'h08, 32'h10); apb(1'b0, 8'h08, 32'h0); check("tempo lo", r, 32'h0fa);
    apb(1'b1, 8'h08, 32'h1000); apb(1'b0, 8'h08, 32'h0); check("tempo hi", r, 32'h9c4);
    apb(1'b1, 8'h04, 32'(tc_t'{5'd1, 6'd2, 6'd3, 5'd4}));
    apb(1'b0, 8'h14, 32'h0); check("abs time", r, 32'(tc_t'{5'd1, 6'd2, 6'd3, 5'd4}));
    apb(1'b1, 8'h00, 32'h0); apb(1'b0, 8'h14, 32'h0); check("rel time", r, 32'h0);
    apb(1'b0, 8'h40, 32'h0); check("unmapped", r, 32'h0);
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h08, 32'h4b0);
  endtask
  // Generator and machine control both off: the line stays silent during play
  task automatic t_silent;
    apb(1'b1, 8'h10, 32'h1);
    repeat (600) @(posedge pclk);
    check("silent", 32'(q.size()), 32'h0);
    park(32'h21);
  endtask
  // Timecode with machine control: play, start, then the first two quarter-frame pieces of zero time
  task automatic t_mtc;
    apb(1'b1, 8'h10, 32'h1);
    expect_bytes("mmc play", {8'hf0, 8'h7f, 8'h7f, 8'h06, 8'h02, 8'hf7});
    expect_bytes("start", {8'hfa});
    expect_bytes("qf pieces", {8'hf1, 8'h00, 8'hf1, 8'h10});
    apb(1'b1, 8'h10, 32'h2);
    q.delete();
    expect_bytes("mmc stop", {8'hf0, 8'h7f, 8'h7f, 8'h06, 8'h01, 8'hf7});
    apb(1'b1, 8'h10, 32'h4);
    expect_bytes("mmc ff", {8'hf0, 8'h7f, 8'h7f, 8'h06, 8'h04, 8'hf7});
    park(32'h42);
  endtask
  // Clock mode from zero: position, then start, then clock ticks
  task automatic t_clock;
    apb(1'b1, 8'h10, 32'h1);
    expect_bytes("clock start", {8'hf2, 8'h00, 8'h00, 8'hfa, 8'hf8, 8'hf8});
    park(32'h08);
  endtask
  // Drop numbering: minute one begins at frame two
  task automatic t_drop;
    tc_t t;
    int n;
    apb(1'b1, 8'h10, 32'h1);
    t = '0;
    n = 0;
    while (t.mm == 6'd0 && n < 20000) begin
      apb(1'b0, 8'h14, 32'h0);
      t = tc_t'(r[21:0]);
      n++;
    end
    check("drop ss", 32'(t.ss), 32'h0);
    check("drop ff", 32'(t.ff), 32'h2);
    park(32'h00);
  endtask
  // Frames per second: the last frame of second zero, then frame zero of second one
  task automatic t_rate(input logic [31:0] ctrl, input logic [4:0] last);
    tc_t t, p;
    park(ctrl);
    apb(1'b1, 8'h10, 32'h1);
    t = '0;
    p = '0;
    while (t.ss == 6'd0) begin
      p = t;
      apb(1'b0, 8'h14, 32'h0);
      t = tc_t'(r[21:0]);
    end
    check("last frame", 32'(p.ff), 32'(last));
    check("rollover", 32'(t.ff), 32'h0);
    park(32'h00);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    park(32'h00);
    t_silent();
    t_mtc();
    t_clock();
    t_drop();
    t_rate(32'h04, 5'd29);
    t_rate(32'h0c, 5'd24);
    t_rate(32'h10, 5'd23);
    check("framing", 32'(ferr), 32'h0);
    finish_test();
  end
endmodule // midi_sync_generator_test
